// ---- rtl/ipoc_defines.svh ----
// register offsets, field positions, reset values and thresholds of the image port control
`ifndef IPOC_DEFINES_SVH
`define IPOC_DEFINES_SVH

`define IPOC_OFS_FMT        8'h85
`define IPOC_OFS_XFER       8'h86
`define IPOC_OFS_CLK        8'h87
`define IPOC_OFS_STAT       8'h8F

`define IPOC_FMT_RST        8'h00
`define IPOC_XFER_RST       8'h00
`define IPOC_CLK_RST        8'h00

`define IPOC_FMT_ORDER      7:6
`define IPOC_FMT_RANGE      5
`define IPOC_FMT_FLAG_A_INV 4
`define IPOC_FMT_FLAG_B_INV 3
`define IPOC_FMT_VERT_INV   2
`define IPOC_FMT_HORIZ_INV  1
`define IPOC_FMT_QUAL_INV   0

`define IPOC_XFER_SEL       7:6
`define IPOC_XFER_A_MSB     5
`define IPOC_XFER_B_MSB     4
`define IPOC_XFER_FULL      3:2
`define IPOC_XFER_EMPTY     1:0

`define IPOC_CLK_GATED_PH   7:6
`define IPOC_CLK_PORT_PH    5:4
`define IPOC_CLK_OE         1:0

`define IPOC_STAT_TRI       6
`define IPOC_STAT_FILLED    5
`define IPOC_STAT_OVF       4

`define IPOC_CLAMP0_LO      8'h01
`define IPOC_CLAMP0_HI      8'hFE
`define IPOC_CLAMP1_LO      8'h08
`define IPOC_CLAMP1_HI      8'hF7

`define IPOC_AE_LVL0        6'h10
`define IPOC_AE_LVL1        6'h08
`define IPOC_AE_LVL2        6'h04
`define IPOC_AF_LVL0        6'h10
`define IPOC_AF_LVL1        6'h18
`define IPOC_AF_LVL2        6'h1C
`define IPOC_AF_LVL3        6'h20

`define IPOC_SKEW_NS        3
`define IPOC_MCLK_MHZ       10
`define IPOC_SKEW_CYC       ((`IPOC_SKEW_NS * `IPOC_MCLK_MHZ + 999) / 1000)

`endif

// ---- rtl/ipoc_pkg.sv ----
// types shared by the image port control modules
package ipoc_pkg;
   typedef enum logic [1:0] {
      IPOC_XFER_OFF,
      IPOC_XFER_VIDEO,
      IPOC_XFER_TEXT,
      IPOC_XFER_BOTH
   } ipoc_xfer_mode_t;

   typedef enum logic [1:0] {
      IPOC_OE_OFF,
      IPOC_OE_ON,
      IPOC_OE_TRI_LOW,
      IPOC_OE_TRI_HIGH
   } ipoc_oe_mode_t;
endpackage : ipoc_pkg

// ---- rtl/ipoc_cfg_if.sv ----
// interface between the port control and its fifo flag unit
`timescale 1ns/1ns
interface ipoc_cfg_if;
   logic [1:0] empty_lvl;
   logic [1:0] full_lvl;
   logic [2:0] sel_a;
   logic [2:0] sel_b;
   logic [5:0] fifo_level;
   logic       fifo_filled;
   logic       fifo_overflow;
   logic       field_id;
   logic       task_flag;
   logic       sliced_flag;
   logic       update;
   logic       nearly_empty;
   logic       nearly_full;
   logic       flag_a;
   logic       flag_b;

   modport ctl (
      output empty_lvl, full_lvl, sel_a, sel_b, fifo_level, fifo_filled,
      output fifo_overflow, field_id, task_flag, sliced_flag, update,
      input  nearly_empty, nearly_full, flag_a, flag_b
   );
   modport flg (
      input  empty_lvl, full_lvl, sel_a, sel_b, fifo_level, fifo_filled,
      input  fifo_overflow, field_id, task_flag, sliced_flag, update,
      output nearly_empty, nearly_full, flag_a, flag_b
   );
endinterface : ipoc_cfg_if

// ---- rtl/ipoc_flags.sv ----
// fifo level flags and general-purpose flag selection
`timescale 1ns/1ns
`include "ipoc_defines.svh"
module ipoc_flags #(
   parameter int FIFO_DEPTH = 32
) (
   input wire logic mclk,
   input wire logic rst_b,
   ipoc_cfg_if.flg  cfg
);
   if (FIFO_DEPTH != 32) begin : g_chk
      $error("ipoc_flags: thresholds are fixed for a 32 dword fifo");
   end

   logic ne_q, ne_d;
   logic nf_q, nf_d;
   logic fa_q, fa_d;
   logic fb_q, fb_d;

   function automatic logic ipoc_ae_hit(input logic [5:0] lvl, input logic [1:0] code);
      case (code)
         2'h0:    ipoc_ae_hit = lvl < `IPOC_AE_LVL0;
         2'h1:    ipoc_ae_hit = lvl < `IPOC_AE_LVL1;
         2'h2:    ipoc_ae_hit = lvl < `IPOC_AE_LVL2;
         default: ipoc_ae_hit = lvl == 6'h00;
      endcase
   endfunction : ipoc_ae_hit

   function automatic logic ipoc_af_hit(input logic [5:0] lvl, input logic [1:0] code);
      case (code)
         2'h0:    ipoc_af_hit = lvl >= `IPOC_AF_LVL0;
         2'h1:    ipoc_af_hit = lvl >= `IPOC_AF_LVL1;
         2'h2:    ipoc_af_hit = lvl >= `IPOC_AF_LVL2;
         default: ipoc_af_hit = lvl == `IPOC_AF_LVL3;
      endcase
   endfunction : ipoc_af_hit

   // one decoder serves both flag outputs
   function automatic logic ipoc_pick(input logic [2:0] sel, input logic ae, input logic af);
      case (sel)
         3'h0:    ipoc_pick = cfg.field_id;
         3'h1:    ipoc_pick = cfg.task_flag;
         3'h2:    ipoc_pick = cfg.sliced_flag;
         3'h3:    ipoc_pick = 1'b0;
         3'h4:    ipoc_pick = cfg.fifo_filled;
         3'h5:    ipoc_pick = cfg.fifo_overflow;
         3'h6:    ipoc_pick = af;
         default: ipoc_pick = ae;
      endcase
   endfunction : ipoc_pick

   always_comb begin
      ne_d = ne_q;
      nf_d = nf_q;
      fa_d = fa_q;
      fb_d = fb_q;
      // re-evaluated from the live level each port clock, nothing is held sticky
      if (cfg.update) begin
         ne_d = ipoc_ae_hit(cfg.fifo_level, cfg.empty_lvl);
         nf_d = ipoc_af_hit(cfg.fifo_level, cfg.full_lvl);
         fa_d = ipoc_pick(cfg.sel_a, ne_d, nf_d);
         fb_d = ipoc_pick(cfg.sel_b, ne_d, nf_d);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ne_q <= 1'b0;
         nf_q <= 1'b0;
         fa_q <= 1'b0;
         fb_q <= 1'b0;
      end else begin
         ne_q <= ne_d;
         nf_q <= nf_d;
         fa_q <= fa_d;
         fb_q <= fb_d;
      end
   end

   assign cfg.nearly_empty = ne_q;
   assign cfg.nearly_full  = nf_q;
   assign cfg.flag_a       = fa_q;
   assign cfg.flag_b       = fb_q;
endmodule : ipoc_flags

// ---- rtl/ipoc_top.sv ----
// image output port control: registers, arbitration, limiting, swap, polarity, phase, enable
`timescale 1ns/1ns
`include "ipoc_defines.svh"
// Functional notes
// - range bit 0 clamps video bytes 1..254
// - range bit 1 clamps video bytes 8..247
// - byte-order field reorders dword bytes
// - qualifier pin inverted when its bit set and gated clock not routed
// - horizontal gate pin inverted when bit set
// - vertical gate pin inverted when bit set
// - each flag output has invert bit
// - transfer code 00 inhibits all output
// - transfer code 01 sends video only
// - code 10 sends text only, no codes
// - code 11 sends both, text first
// - empty level code sets almost-empty threshold
// - full level code sets almost-full threshold
// - two bits extend flag selectors to three
// - port clock phase: invert and/or skew
// - gated clock phase: invert and/or skew
// - gated phase acts only when gated routed
// - enable 00 floats, 01 drives port
// - enable 10/11 follow tristate pin level
// - selector codes 4..7 pick fifo flags
module ipoc_top #(
   parameter int FIFO_DEPTH = 32
) (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output wire logic [7:0]  reg_rdata,
   input  wire logic [1:0]  flag_a_sel_lo,
   input  wire logic [1:0]  flag_b_sel_lo,
   input  wire logic        gated_clk_route,
   input  wire logic        port_clk_in,
   input  wire logic        tristate_ctl_pin,
   input  wire logic [31:0] vid_data,
   input  wire logic        vid_valid,
   input  wire logic        vid_is_code,
   output wire logic        vid_ack,
   input  wire logic [31:0] txt_data,
   input  wire logic        txt_valid,
   output wire logic        txt_ack,
   input  wire logic        hgate_in,
   input  wire logic        vgate_in,
   input  wire logic        field_id,
   input  wire logic        task_flag,
   input  wire logic        sliced_flag,
   input  wire logic [5:0]  fifo_level,
   input  wire logic        fifo_filled,
   input  wire logic        fifo_overflow,
   output wire logic        port_out_clock,
   output wire logic        data_qualifier_pin,
   output wire logic        horiz_gate_pin,
   output wire logic        vert_gate_pin,
   output wire logic        flag_out_a_pin,
   output wire logic        flag_out_b_pin,
   output wire logic [31:0] port_data,
   output wire logic        port_oe
);
   if (`IPOC_SKEW_CYC != 1) begin : g_chk
      $error("ipoc_top: skew tap is one mclk period deep");
   end

   // register file
   logic [7:0] fmt_q,   fmt_d;
   logic [7:0] xfer_q,  xfer_d;
   logic [7:0] clkc_q,  clkc_d;
   logic [7:0] rdata_q, rdata_d;

   // synchronisers for pins from outside the mclk domain
   logic clk_s1_q, clk_s2_q, clk_s3_q;
   logic tri_s1_q, tri_s2_q;
   logic pclk_rise;

   // port word state
   logic [31:0] data_q, data_d;
   logic        qual_q, qual_d;
   logic        vack_q, vack_d;
   logic        tack_q, tack_d;

   // pin flops
   logic pclk_q, pclk_d;
   logic dq_q,   dq_d;
   logic hg_q,   hg_d;
   logic vg_q,   vg_d;
   logic ga_q,   ga_d;
   logic gb_q,   gb_d;
   logic oe_q,   oe_d;

   ipoc_pkg::ipoc_xfer_mode_t xmode;
   ipoc_pkg::ipoc_oe_mode_t   omode;
   logic [31:0] vid_clamped;
   logic [7:0]  clamp_lo;
   logic [7:0]  clamp_hi;
   logic        take_txt;
   logic        take_vid;
   logic        clk_base;
   logic        gate_base;

   ipoc_cfg_if cfg ();

   assign xmode = ipoc_pkg::ipoc_xfer_mode_t'(xfer_q[`IPOC_XFER_SEL]);
   assign omode = ipoc_pkg::ipoc_oe_mode_t'(clkc_q[`IPOC_CLK_OE]);

   always_comb begin
      fmt_d   = fmt_q;
      xfer_d  = xfer_q;
      clkc_d  = clkc_q;
      rdata_d = rdata_q;
      if (reg_wr) begin
         if (reg_addr == `IPOC_OFS_FMT) begin
            fmt_d = reg_wdata;
         end else if (reg_addr == `IPOC_OFS_XFER) begin
            xfer_d = reg_wdata;
         end else if (reg_addr == `IPOC_OFS_CLK) begin
            clkc_d = reg_wdata;
         end
      end
      if (reg_rd) begin
         if (reg_addr == `IPOC_OFS_FMT) begin
            rdata_d = fmt_q;
         end else if (reg_addr == `IPOC_OFS_XFER) begin
            rdata_d = xfer_q;
         end else if (reg_addr == `IPOC_OFS_CLK) begin
            rdata_d = clkc_q;
         end else if (reg_addr == `IPOC_OFS_STAT) begin
            rdata_d                    = 8'h00;
            rdata_d[`IPOC_STAT_TRI]    = tri_s2_q;
            rdata_d[`IPOC_STAT_FILLED] = fifo_filled;
            rdata_d[`IPOC_STAT_OVF]    = fifo_overflow;
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fmt_q   <= `IPOC_FMT_RST;
         xfer_q  <= `IPOC_XFER_RST;
         clkc_q  <= `IPOC_CLK_RST;
         rdata_q <= 8'h00;
      end else begin
         fmt_q   <= fmt_d;
         xfer_q  <= xfer_d;
         clkc_q  <= clkc_d;
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         clk_s1_q <= 1'b0;
         clk_s2_q <= 1'b0;
         clk_s3_q <= 1'b0;
         tri_s1_q <= 1'b0;
         tri_s2_q <= 1'b0;
      end else begin
         clk_s1_q <= port_clk_in;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q;
         tri_s1_q <= tristate_ctl_pin;
         tri_s2_q <= tri_s1_q;
      end
   end

   assign pclk_rise = clk_s2_q & ~clk_s3_q;

   assign clamp_lo = fmt_q[`IPOC_FMT_RANGE] ? `IPOC_CLAMP1_LO : `IPOC_CLAMP0_LO;
   assign clamp_hi = fmt_q[`IPOC_FMT_RANGE] ? `IPOC_CLAMP1_HI : `IPOC_CLAMP0_HI;

   for (genvar i = 0; i < 4; i++) begin : g_clamp
      logic [7:0] b;
      assign b = vid_data[8*i +: 8];
      assign vid_clamped[8*i +: 8] = (b < clamp_lo) ? clamp_lo :
                                     ((b > clamp_hi) ? clamp_hi : b);
   end

   function automatic logic [31:0] ipoc_swap(input logic [31:0] w, input logic [1:0] ord);
      case (ord)
         2'h0:    ipoc_swap = w;
         2'h1:    ipoc_swap = {w[23:16], w[31:24], w[7:0], w[15:8]};
         2'h2:    ipoc_swap = {w[15:0], w[31:16]};
         default: ipoc_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
      endcase
   endfunction : ipoc_swap

   // text wins when both sources are pending in the both-sources mode (code 11); video never moves in text-only mode
   assign take_txt = txt_valid && (xmode == ipoc_pkg::IPOC_XFER_TEXT ||
                                   xmode == ipoc_pkg::IPOC_XFER_BOTH);
   assign take_vid = vid_valid && !take_txt &&
                     (xmode == ipoc_pkg::IPOC_XFER_VIDEO ||
                      xmode == ipoc_pkg::IPOC_XFER_BOTH);

   always_comb begin
      data_d = data_q;
      qual_d = qual_q;
      vack_d = 1'b0;
      tack_d = 1'b0;
      if (pclk_rise) begin
         qual_d = take_txt | take_vid;
         tack_d = take_txt;
         vack_d = take_vid;
         if (take_txt) begin
            data_d = ipoc_swap(txt_data, fmt_q[`IPOC_FMT_ORDER]);
         end else if (take_vid) begin
            // timing codes bypass the limiter so FF 00 00 headers survive
            data_d = ipoc_swap(vid_is_code ? vid_data : vid_clamped,
                               fmt_q[`IPOC_FMT_ORDER]);
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         data_q <= 32'h0000_0000;
         qual_q <= 1'b0;
         vack_q <= 1'b0;
         tack_q <= 1'b0;
      end else begin
         data_q <= data_d;
         qual_q <= qual_d;
         vack_q <= vack_d;
         tack_q <= tack_d;
      end
   end

   assign cfg.empty_lvl     = xfer_q[`IPOC_XFER_EMPTY];
   assign cfg.full_lvl      = xfer_q[`IPOC_XFER_FULL];
   assign cfg.sel_a         = {xfer_q[`IPOC_XFER_A_MSB], flag_a_sel_lo};
   assign cfg.sel_b         = {xfer_q[`IPOC_XFER_B_MSB], flag_b_sel_lo};
   assign cfg.fifo_level    = fifo_level;
   assign cfg.fifo_filled   = fifo_filled;
   assign cfg.fifo_overflow = fifo_overflow;
   assign cfg.field_id      = field_id;
   assign cfg.task_flag     = task_flag;
   assign cfg.sliced_flag   = sliced_flag;
   assign cfg.update        = pclk_rise;

   ipoc_flags #(
      .FIFO_DEPTH (FIFO_DEPTH)
   ) u_flags (
      .mclk  (mclk),
      .rst_b (rst_b),
      .cfg   (cfg)
   );

   // the 3 ns skew is one mclk tap: coarse at 10 MHz, but keeps the setting observable
   assign clk_base  = clkc_q[5] ? clk_s3_q : clk_s2_q;
   assign gate_base = clkc_q[7] ? clk_s3_q : clk_s2_q;

   always_comb begin
      // only bits 5:4 steer the port clock; the gated phase bits never reach it
      pclk_d = clk_base ^ clkc_q[4];
      if (gated_clk_route) begin
         // phase is applied before gating: while the qualifier is low the pin stays low
         // whatever the phase setting, so the receiver sees no stray edges between
         // words
         dq_d = (gate_base ^ clkc_q[6]) & qual_q;
      end else begin
         dq_d = qual_q ^ fmt_q[`IPOC_FMT_QUAL_INV];
      end
      hg_d = hgate_in ^ fmt_q[`IPOC_FMT_HORIZ_INV];
      vg_d = vgate_in ^ fmt_q[`IPOC_FMT_VERT_INV];
      ga_d = cfg.flag_a ^ fmt_q[`IPOC_FMT_FLAG_A_INV];
      gb_d = cfg.flag_b ^ fmt_q[`IPOC_FMT_FLAG_B_INV];
      case (omode)
         ipoc_pkg::IPOC_OE_OFF:      oe_d = 1'b0;
         ipoc_pkg::IPOC_OE_ON:       oe_d = 1'b1;
         ipoc_pkg::IPOC_OE_TRI_LOW:  oe_d = ~tri_s2_q;
         default:                    oe_d = tri_s2_q;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pclk_q <= 1'b0;
         dq_q   <= 1'b0;
         hg_q   <= 1'b0;
         vg_q   <= 1'b0;
         ga_q   <= 1'b0;
         gb_q   <= 1'b0;
         oe_q   <= 1'b0;
      end else begin
         pclk_q <= pclk_d;
         dq_q   <= dq_d;
         hg_q   <= hg_d;
         vg_q   <= vg_d;
         ga_q   <= ga_d;
         gb_q   <= gb_d;
         oe_q   <= oe_d;
      end
   end

   assign reg_rdata          = rdata_q;
   assign vid_ack            = vack_q;
   assign txt_ack            = tack_q;
   assign port_out_clock     = pclk_q;
   assign data_qualifier_pin = dq_q;
   assign horiz_gate_pin     = hg_q;
   assign vert_gate_pin      = vg_q;
   assign flag_out_a_pin     = ga_q;
   assign flag_out_b_pin     = gb_q;
   assign port_data          = data_q;
   assign port_oe            = oe_q;

   function automatic logic ipoc_in_rng(input logic [31:0] w, input logic [7:0] lo,
                                        input logic [7:0] hi);
      ipoc_in_rng = 1'b1;
      for (int k = 0; k < 4; k++) begin
         if (w[8*k +: 8] < lo || w[8*k +: 8] > hi) begin
            ipoc_in_rng = 1'b0;
         end
      end
   endfunction : ipoc_in_rng

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   property p_clamp_wide;
      pclk_rise && take_vid && !vid_is_code && !fmt_q[`IPOC_FMT_RANGE] &&
      !(reg_wr && reg_addr == `IPOC_OFS_FMT)
      |=> ipoc_in_rng(port_data, 8'h01, 8'hFE);
   endproperty
   a_clamp_wide: assert property (p_clamp_wide) else $error("video byte outside 1..254");

   property p_clamp_narrow;
      pclk_rise && take_vid && !vid_is_code && fmt_q[`IPOC_FMT_RANGE] &&
      !(reg_wr && reg_addr == `IPOC_OFS_FMT)
      |=> ipoc_in_rng(port_data, 8'h08, 8'hF7);
   endproperty
   a_clamp_narrow: assert property (p_clamp_narrow) else $error("video byte outside 8..247");

   property p_swap_rev;
      pclk_rise && take_txt && fmt_q[`IPOC_FMT_ORDER] == 2'h3
      |=> port_data[7:0] == $past(txt_data[31:24]) && port_data[31:24] == $past(txt_data[7:0]);
   endproperty
   a_swap_rev: assert property (p_swap_rev) else $error("reverse byte order wrong");

   property p_qual_pol;
      pclk_rise && (take_txt || take_vid) && !gated_clk_route && !fmt_q[`IPOC_FMT_QUAL_INV]
      ##1 !gated_clk_route && !fmt_q[`IPOC_FMT_QUAL_INV] |=> data_qualifier_pin;
   endproperty
   a_qual_pol: assert property (p_qual_pol) else $error("qualifier not active high");

   property p_horiz_pol;
      ##1 1'b1 |-> horiz_gate_pin == ($past(hgate_in) ^ $past(fmt_q[`IPOC_FMT_HORIZ_INV]));
   endproperty
   a_horiz_pol: assert property (p_horiz_pol) else $error("horizontal gate polarity wrong");

   property p_vert_inv;
      fmt_q[`IPOC_FMT_VERT_INV] |=> vert_gate_pin != $past(vgate_in);
   endproperty
   a_vert_inv: assert property (p_vert_inv) else $error("vertical gate not inverted");

   property p_inhibit;
      xmode == ipoc_pkg::IPOC_XFER_OFF |=> !vid_ack && !txt_ack;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("data taken while inhibited");

   property p_text_only;
      xmode == ipoc_pkg::IPOC_XFER_TEXT |=> !vid_ack;
   endproperty
   a_text_only: assert property (p_text_only) else $error("video taken in text mode");

   property p_text_first;
      pclk_rise && xmode == ipoc_pkg::IPOC_XFER_BOTH && txt_valid && vid_valid
      |=> txt_ack && !vid_ack ##1 !txt_ack;
   endproperty
   a_text_first: assert property (p_text_first) else $error("text lost priority");

   property p_oe_follow;
      omode == ipoc_pkg::IPOC_OE_TRI_LOW |=> port_oe == !$past(tri_s2_q);
   endproperty
   a_oe_follow: assert property (p_oe_follow) else $error("enable ignores tristate pin");

   property p_oe_off;
      omode == ipoc_pkg::IPOC_OE_OFF [*2] |-> !port_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("port driven while disabled");

   c_video: cover property (pclk_rise && take_vid ##1 vid_ack);
   c_text:  cover property (pclk_rise && take_txt ##1 txt_ack);
   c_oe:    cover property (!port_oe ##1 port_oe);
endmodule : ipoc_top

// ---- testbench/ipoc_rx_model.sv ----
// back-end receiver model: drives the port clock toward the image port
`timescale 1ns/1ns
module ipoc_rx_model (
   input  wire logic run,
   output logic      port_clk_in
);
   // clock stands still low between frames; odd offset keeps it off the mclk grid
   initial begin
      port_clk_in = 1'b0;
      #37;
      forever #400 port_clk_in = run ? ~port_clk_in : 1'b0;
   end
endmodule : ipoc_rx_model

// ---- testbench/test_ipoc_top.sv ----
// self-checking bench of the image port control
`timescale 1ns/1ns
module test_ipoc_top;
   logic        mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [1:0]  flag_a_sel_lo = 2'h3, flag_b_sel_lo = 2'h2;
   logic        gated_clk_route = 1'b0, tristate_ctl_pin = 1'b0, vid_valid = 1'b0;
   logic        vid_is_code = 1'b0, txt_valid = 1'b0, hgate_in = 1'b0, vgate_in = 1'b0;
   logic        field_id = 1'b0, task_flag = 1'b0, sliced_flag = 1'b0;
   logic        fifo_filled = 1'b0, fifo_overflow = 1'b0;
   logic [5:0]  fifo_level = 6'h00;
   logic [31:0] vid_data = 32'h0005FAFF, txt_data = 32'h12345678;
   logic [7:0]  reg_rdata;
   logic [31:0] port_data;
   logic        port_clk_in, port_out_clock, data_qualifier_pin, horiz_gate_pin, vert_gate_pin;
   logic        flag_out_a_pin, flag_out_b_pin, port_oe, vid_ack, txt_ack, v, t;
   int          err_total = 0, compares = 0, acks = 0, a0 = 0;
   logic [3:0]  pin_hist = 4'h0;
   int          e_lvl[4] = '{16, 8, 4, 1};
   int          f_lvl[4] = '{16, 24, 28, 32};

   ipoc_top u_ipoc_top (.mclk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .flag_a_sel_lo, .flag_b_sel_lo, .gated_clk_route, .port_clk_in, .tristate_ctl_pin,
      .vid_data, .vid_valid, .vid_is_code, .vid_ack, .txt_data, .txt_valid, .txt_ack,
      .hgate_in, .vgate_in, .field_id, .task_flag, .sliced_flag, .fifo_level, .fifo_filled,
      .fifo_overflow, .port_out_clock, .data_qualifier_pin, .horiz_gate_pin, .vert_gate_pin,
      .flag_out_a_pin, .flag_out_b_pin, .port_data, .port_oe);
   ipoc_rx_model u_ipoc_rx_model (.run, .port_clk_in);

   always #50 mclk = ~mclk;
   always @(posedge mclk) acks <= acks + int'(vid_ack === 1'b1) + int'(txt_ack === 1'b1);
   // port clock pin as the design's synchroniser saw it, newest sample in bit 0
   always @(posedge mclk) pin_hist <= {pin_hist[2:0], port_clk_in};

   task automatic final_report;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // every bus task starts and ends right after a rising mclk edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      chk(reg_rdata, exp);
   endtask : rdchk

   task automatic wait_ack;
      int i;
      v = 1'b0;
      t = 1'b0;
      for (i = 0; i < 40 && v !== 1'b1 && t !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
         v = vid_ack;
         t = txt_ack;
      end
      if (v !== 1'b1 && t !== 1'b1) begin
         err_total++;
         final_report();
      end else begin
         @(posedge mclk);
      end
   endtask : wait_ack

   // a word and its clamp and byte order, b0 being the low byte
   function automatic logic [31:0] expw(input int r, input int o);
      logic [7:0] b[4];
      logic [7:0] lo, hi;
      lo = r ? 8'h08 : 8'h01;
      hi = r ? 8'hF7 : 8'hFE;
      b = '{8'hFF, 8'hFA, 8'h05, 8'h00};
      foreach (b[i]) b[i] = b[i] < lo ? lo : (b[i] > hi ? hi : b[i]);
      case (o)
         0: return {b[3], b[2], b[1], b[0]};
         1: return {b[2], b[3], b[0], b[1]};
         2: return {b[1], b[0], b[3], b[2]};
         default: return {b[0], b[1], b[2], b[3]};
      endcase
   endfunction : expw

   initial begin
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      foreach (e_lvl[i]) rdchk(8'h85 + 8'(i), 8'h00);
      rdchk(8'h90, 8'h00);
      wr(8'h8F, 8'hFF);
      rdchk(8'h8F, 8'h00);
      for (int m = 0; m < 8; m++) begin
         wr(8'h87, 8'(m[2:1]));
         tristate_ctl_pin <= m[0];
         repeat (6) @(posedge mclk);
         chk(port_oe, m == 2 || m == 3 || m == 4 || m == 7);
      end
      rdchk(8'h8F, 8'h40);
      run <= 1'b1;
      wr(8'h86, 8'h40);
      for (int k = 0; k < 8; k++) begin
         wr(8'h85, {k[1:0], k[2], 5'h00});
         vid_valid <= 1'b1;
         wait_ack();
         vid_valid <= 1'b0;
         chk({v, t}, 2'b10);
         chk(port_data, expw(k[2], k[1:0]));
      end
      // port and gated clock follow the pin three or four mclk edges back
      @(posedge mclk);
      vid_valid <= 1'b1;
      gated_clk_route <= 1'b1;
      for (int ph = 0; ph < 4; ph++) begin
         wr(8'h87, {~ph[1:0], ph[1:0], 4'h1});
         repeat (10) @(posedge mclk);
         repeat (16) begin
            @(posedge mclk);
            chk(port_out_clock, pin_hist[2 + ph[1]] ^ ph[0]);
            chk(data_qualifier_pin, pin_hist[3 - ph[1]] ^ !ph[0]);
         end
      end
      vid_valid <= 1'b0;
      wr(8'h87, 8'h41);
      repeat (20) @(posedge mclk);
      chk(data_qualifier_pin, 1'b0);
      gated_clk_route <= 1'b0;
      wr(8'h85, 8'hC0);
      wr(8'h86, 8'hC0);
      vid_valid <= 1'b1;
      txt_valid <= 1'b1;
      wait_ack();
      txt_valid <= 1'b0;
      chk({v, t}, 2'b01);
      chk(port_data, 32'h78563412);
      wait_ack();
      chk({v, t}, 2'b10);
      chk(port_data, expw(0, 3));
      vid_is_code <= 1'b1;
      wr(8'h86, 8'h80);
      a0 = acks;
      repeat (20) @(posedge mclk);
      chk(acks - a0, 0);
      txt_valid <= 1'b1;
      wait_ack();
      chk({v, t}, 2'b01);
      wr(8'h86, 8'h00);
      a0 = acks;
      repeat (20) @(posedge mclk);
      chk(acks - a0, 0);
      hgate_in <= 1'b1;
      for (int p = 0; p < 8; p++) begin
         wr(8'h85, 8'(p));
         repeat (3) @(posedge mclk);
         chk({data_qualifier_pin, horiz_gate_pin, vert_gate_pin},
             {p[0], !p[1], p[2]});
      end
      // flag a shows nearly empty, flag b nearly full; the upper half of j inverts both
      for (int j = 0; j < 8; j++) begin
         wr(8'h85, j[2] ? 8'h18 : 8'h00);
         wr(8'h86, {2'b00, 2'b11, j[1:0], j[1:0]});
         for (int s = 0; s < 2; s++) begin
            fifo_level <= 6'(s ? f_lvl[j[1:0]] : e_lvl[j[1:0]] - 1);
            repeat (20) @(posedge mclk);
            chk({flag_out_a_pin, flag_out_b_pin},
                {!s[0] ^ j[2], s[0] ^ j[2]});
         end
      end
      flag_a_sel_lo <= 2'h0;
      flag_b_sel_lo <= 2'h1;
      fifo_filled <= 1'b1;
      task_flag <= 1'b1;
      repeat (20) @(posedge mclk);
      chk({flag_out_a_pin, flag_out_b_pin}, 2'b01);
      wr(8'h86, 8'h20);
      repeat (20) @(posedge mclk);
      chk({flag_out_a_pin, flag_out_b_pin}, 2'b00);
      final_report();
   end
endmodule : test_ipoc_top
